// ### hw/dma_pkg.sv
package dma_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SRC_OFS = 8'h08;
	localparam logic [7:0] DST_OFS = 8'h0c;
	localparam logic [7:0] COUNT_OFS = 8'h10;
	localparam logic [7:0] MASK_OFS = 8'h14;

	// Channel mode field positions
	localparam int MODE_START = 0;
	localparam int MODE_SWRST = 1;
	localparam int MODE_BT_LO = 2;
	localparam int MODE_BT_HI = 3;
	localparam int MODE_DSIZE_LO = 4;
	localparam int MODE_DSIZE_HI = 5;
	localparam int MODE_SSIZE_LO = 6;
	localparam int MODE_SSIZE_HI = 7;
	localparam int MODE_DINC = 8;
	localparam int MODE_SINC = 9;
	localparam int MODE_REQ_LO = 10;
	localparam int MODE_REQ_HI = 11;
	localparam int MODE_INT_ON_ERROR_EN = 12;
	localparam int MODE_INT_ON_NORMAL_EN = 13;
	localparam int MODE_PERIPH_DST = 14;

	// Channel status bit positions
	localparam int STAT_DONE = 0;
	localparam int STAT_WERR = 1;
	localparam int STAT_RERR = 2;
	localparam int STAT_UNSYNC = 3;

	// Interrupt mask enable for this channel
	localparam int MASK_CHAN_EN = 11;

	// Request modes and operand sizes
	localparam logic [1:0] REQ_INT_THROTTLE = 2'h0;
	localparam logic [1:0] REQ_INT_BURST = 2'h1;
	localparam logic [1:0] REQ_EXT_BURST = 2'h2;
	localparam logic [1:0] REQ_EXT_STEAL = 2'h3;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Idle gap after each throttled operand, per bandwidth setting
	localparam logic [5:0] GAP_75 = 6'h01;
	localparam logic [5:0] GAP_50 = 6'h03;
	localparam logic [5:0] GAP_25 = 6'h09;
	localparam logic [5:0] GAP_12 = 6'h15;

	// Reset values and fixed interrupt level
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [2:0] IRQ_LEVEL = 3'h4;
	localparam logic [2:0] IRQ_NONE = 3'h0;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_ARB = 5'h02,
		S_READ = 5'h04,
		S_WRITE = 5'h08,
		S_GAP = 5'h10
	} state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic rd;
		logic wr;
		logic byte_size;
		logic [23:0] addr;
		logic [15:0] wdata;
	} sys_req_type;

	typedef struct packed {
		logic [15:0] rdata;
		logic ack;
		logic err;
	} sys_rsp_type;
endpackage : dma_pkg

// ### hw/dma_channel.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module dma_channel
	import dma_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire apb_req_type i_apb,
	output apb_rsp_type o_apb,
	output sys_req_type o_bus,
	input wire sys_rsp_type i_bus,
	input wire logic i_core_busy,
	input wire logic i_ext_master,
	input wire logic i_xfer_request_n,
	output logic o_xfer_ack_n,
	output logic o_bus_grant_ack_n,
	input wire logic i_term_n,
	output logic o_term_n,
	output logic o_term_oe,
	output logic [2:0] o_int_level
);

	typedef struct packed {
		state_type st;
		logic [15:0] mode;
		logic [7:0] status;
		logic [15:0] mask;
		logic [23:0] src;
		logic [23:0] dst;
		logic [15:0] cnt;
		logic [15:0] data;
		logic second;
		logic req_prev;
		logic pend;
		logic term_seen;
		logic [5:0] gap;
		apb_rsp_type apb;
		sys_req_type bus;
		logic xack_n;
		logic bga_n;
		logic term_n;
		logic term_oe;
		logic [2:0] irq;
	} chan_state_type;

	chan_state_type q, d;

	// Next-state logic: register file, request capture, operand sequencer
	always_comb begin
		logic take;
		logic [1:0] rmode;
		logic ext;
		logic pack;
		logic dbyte;
		logic sbyte;
		logic last;
		logic [15:0] dbytes;
		logic [7:0] rbyte;
		logic go_read;
		logic go_write;
		logic release_bus;
		logic ended;
		logic req;
		take = 1'b0;
		rmode = 2'h0;
		ext = 1'b0;
		pack = 1'b0;
		dbyte = 1'b0;
		sbyte = 1'b0;
		last = 1'b0;
		dbytes = 16'h0000;
		rbyte = 8'h00;
		go_read = 1'b0;
		go_write = 1'b0;
		release_bus = 1'b0;
		ended = 1'b0;
		req = 1'b0;
		d = q;

		// APB slave: one wait state, write lands on the pready edge
		take = i_apb.psel && i_apb.penable && q.apb.pready;
		d.apb.pready = i_apb.psel && i_apb.penable && !q.apb.pready;
		if (i_apb.psel && i_apb.penable && !q.apb.pready) begin
			d.apb.pslverr = 1'b0;
			case (i_apb.paddr)
				MODE_OFS: d.apb.prdata = {16'h0000, q.mode};
				STATUS_OFS: d.apb.prdata = {24'h000000, q.status};
				SRC_OFS: d.apb.prdata = {8'h00, q.src};
				DST_OFS: d.apb.prdata = {8'h00, q.dst};
				COUNT_OFS: d.apb.prdata = {16'h0000, q.cnt};
				MASK_OFS: d.apb.prdata = {16'h0000, q.mask};
				default: begin
					d.apb.prdata = 32'h00000000;
					d.apb.pslverr = 1'b1;
				end
			endcase
		end
		if (take && i_apb.pwrite) begin
			case (i_apb.paddr)
				MODE_OFS: d.mode = i_apb.pwdata[15:0];
				STATUS_OFS: d.status = q.status & ~i_apb.pwdata[7:0];
				SRC_OFS: d.src = i_apb.pwdata[23:0];
				DST_OFS: d.dst = i_apb.pwdata[23:0];
				COUNT_OFS: d.cnt = i_apb.pwdata[15:0];
				MASK_OFS: d.mask = i_apb.pwdata[15:0];
				default: d.mode = q.mode;
			endcase
		end

		// Decoded mode, based on the stored copy
		rmode = q.mode[MODE_REQ_HI:MODE_REQ_LO];
		ext = rmode[1];
		sbyte = q.mode[MODE_SSIZE_HI:MODE_SSIZE_LO] == SIZE_BYTE;
		dbyte = q.mode[MODE_DSIZE_HI:MODE_DSIZE_LO] == SIZE_BYTE;
		pack = sbyte && (q.mode[MODE_DSIZE_HI:MODE_DSIZE_LO] == SIZE_WORD);
		dbytes = dbyte ? 16'h0001 : 16'h0002;
		last = q.cnt <= dbytes;
		rbyte = q.bus.addr[0] ? i_bus.rdata[7:0] : i_bus.rdata[15:8];

		// Edge capture for cycle steal; a new edge beats consumption
		d.req_prev = !i_xfer_request_n;
		if (rmode == REQ_EXT_STEAL && !i_xfer_request_n && !q.req_prev) begin
			d.pend = 1'b1;
		end
		req = q.mode[MODE_START] && (!ext || (rmode == REQ_EXT_BURST && !i_xfer_request_n) ||
			(rmode == REQ_EXT_STEAL && q.pend));

		// Operand sequencer
		case (q.st)
			S_IDLE: begin
				// A zero count never leaves idle; start alone moves nothing
				if (req && q.cnt != 16'h0000) begin
					d.st = S_ARB;
				end
			end
			S_ARB: begin
				// Wait for the core cycle and any outside master to finish
				if (!i_core_busy && !i_ext_master) begin
					d.bga_n = 1'b0;
					d.term_seen = 1'b0;
					go_read = 1'b1;
				end
			end
			S_READ: begin
				if (i_bus.err) begin
					d.status[STAT_RERR] = 1'b1;
					release_bus = 1'b1;
					ended = 1'b1;
				end else if (i_bus.ack) begin
					if (ext && !q.mode[MODE_PERIPH_DST] && !i_term_n && !q.term_oe) begin
						d.term_seen = 1'b1;
						if (pack && !q.second) begin
							d.status[STAT_UNSYNC] = 1'b1;
						end
					end
					if (!sbyte) begin
						d.data = i_bus.rdata;
					end else if (pack && !q.second) begin
						d.data[15:8] = rbyte;
					end else if (pack) begin
						d.data[7:0] = rbyte;
					end else begin
						d.data = {rbyte, rbyte};
					end
					// Packing keeps every read on one byte lane
					if (q.mode[MODE_SINC]) begin
						d.src = q.src + ((sbyte && !pack) ? 24'h000001 : 24'h000002);
					end
					if (pack && !q.second) begin
						d.second = 1'b1;
						go_read = 1'b1;
					end else begin
						d.second = 1'b0;
						go_write = 1'b1;
					end
				end
			end
			S_WRITE: begin
				if (i_bus.err) begin
					d.status[STAT_WERR] = 1'b1;
					release_bus = 1'b1;
					ended = 1'b1;
				end else if (i_bus.ack) begin
					if (ext && q.mode[MODE_PERIPH_DST] && !i_term_n && !q.term_oe) begin
						d.term_seen = 1'b1;
					end
					// Count stops at zero so an odd tail cannot wrap around
					d.cnt = last ? 16'h0000 : q.cnt - dbytes;
					if (q.mode[MODE_DINC]) begin
						d.dst = q.dst + (dbyte ? 24'h000001 : 24'h000002);
					end
					// Completion only reached on an error-free write
					if (last || d.term_seen) begin
						d.status[STAT_DONE] = 1'b1;
						ended = 1'b1;
					end
					if (!ended && q.mode[MODE_START] && (rmode == REQ_INT_BURST ||
						(rmode == REQ_EXT_BURST && !i_xfer_request_n))) begin
						go_read = 1'b1;
					end else begin
						release_bus = 1'b1;
					end
				end
			end
			S_GAP: begin
				// Idle until the gap runs out, then arbitrate like a fresh request
				if (q.gap == 6'h00) begin
					d.st = S_IDLE;
				end else begin
					d.gap = q.gap - 6'h01;
				end
			end
			default: d.st = S_IDLE;
		endcase

		// Start a bus read from the source pointer
		if (go_read) begin
			d.st = S_READ;
			d.bus.rd = 1'b1;
			d.bus.wr = 1'b0;
			d.bus.addr = d.src;
			d.bus.byte_size = sbyte;
			d.xack_n = !(ext && !q.mode[MODE_PERIPH_DST]);
			d.term_oe = ext && !q.mode[MODE_PERIPH_DST] && last && !(pack && !d.second);
			d.term_n = !d.term_oe;
			if (q.st == S_ARB || q.st == S_WRITE) begin
				d.pend = 1'b0;
				if (rmode == REQ_EXT_STEAL && !i_xfer_request_n && !q.req_prev) begin
					d.pend = 1'b1;
				end
			end
		end
		// Start a bus write to the destination pointer
		if (go_write) begin
			d.st = S_WRITE;
			d.bus.rd = 1'b0;
			d.bus.wr = 1'b1;
			d.bus.addr = q.dst;
			d.bus.byte_size = dbyte;
			d.bus.wdata = dbyte ? {d.data[7:0], d.data[7:0]} : d.data;
			d.xack_n = !(ext && q.mode[MODE_PERIPH_DST]);
			d.term_oe = ext && q.mode[MODE_PERIPH_DST] && last;
			d.term_n = !d.term_oe;
		end
		// Give the bus back; ack and terminate go idle with it
		if (release_bus) begin
			d.bus.rd = 1'b0;
			d.bus.wr = 1'b0;
			d.bga_n = 1'b1;
			d.xack_n = 1'b1;
			d.term_oe = 1'b0;
			d.term_n = 1'b1;
			d.second = 1'b0;
			if (!ended && rmode == REQ_INT_THROTTLE) begin
				d.st = S_GAP;
				case (q.mode[MODE_BT_HI:MODE_BT_LO])
					2'h0: d.gap = GAP_75;
					2'h1: d.gap = GAP_50;
					2'h2: d.gap = GAP_25;
					default: d.gap = GAP_12;
				endcase
			end else begin
				d.st = S_IDLE;
			end
		end
		if (ended) begin
			d.mode[MODE_START] = 1'b0;
		end

		// Software reset aborts the block and wipes the flags
		if (d.mode[MODE_SWRST]) begin
			d.status = STATUS_RESET;
			d.mode[MODE_START] = 1'b0;
			d.st = S_IDLE;
			d.bus.rd = 1'b0;
			d.bus.wr = 1'b0;
			d.bga_n = 1'b1;
			d.xack_n = 1'b1;
			d.term_oe = 1'b0;
			d.term_n = 1'b1;
			d.pend = 1'b0;
			d.second = 1'b0;
		end

		// Level-four request gated by mask and mode enables
		d.irq = (d.mask[MASK_CHAN_EN] && ((d.mode[MODE_INT_ON_NORMAL_EN] && d.status[STAT_DONE]) ||
			(d.mode[MODE_INT_ON_ERROR_EN] && (d.status[STAT_RERR] || d.status[STAT_WERR])))) ?
			IRQ_LEVEL : IRQ_NONE;
	end

	// State register; reset also idles the grant ack pin high
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// Blanket clear first, then the strobes that idle high
			q <= '0;
			q.st <= S_IDLE;
			q.mode <= MODE_RESET;
			q.status <= STATUS_RESET;
			q.mask <= MASK_RESET;
			q.xack_n <= 1'b1;
			q.bga_n <= 1'b1;
			q.term_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign o_apb = q.apb;
	assign o_bus = q.bus;
	assign o_xfer_ack_n = q.xack_n;
	assign o_bus_grant_ack_n = q.bga_n;
	assign o_term_n = q.term_n;
	assign o_term_oe = q.term_oe;
	assign o_int_level = q.irq;

endmodule : dma_channel

// ### verif/dma_channel_chk.sv
`timescale 1ns/1ns
module dma_channel_chk
	import dma_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire sys_req_type o_bus,
	input wire sys_rsp_type i_bus,
	input wire logic i_core_busy,
	input wire logic i_ext_master,
	input wire logic o_xfer_ack_n,
	input wire logic o_bus_grant_ack_n,
	input wire logic o_term_n,
	input wire logic o_term_oe,
	input wire logic [2:0] o_int_level
);
	// Single domain, so clock and reset are stated once
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_int_fixed: assert property (o_int_level != IRQ_NONE |-> o_int_level == IRQ_LEVEL)
		else $error("interrupt level off");
	a_term_low: assert property (o_term_oe |-> !o_term_n)
		else $error("terminate driven high");
	a_term_owned: assert property (o_term_oe |-> !o_bus_grant_ack_n)
		else $error("terminate without bus");
	a_ack_access: assert property (!o_xfer_ack_n |-> !o_bus_grant_ack_n && (o_bus.rd || o_bus.wr))
		else $error("ack outside access");
	a_grant_free: assert property ($fell(o_bus_grant_ack_n) |-> !$past(i_core_busy) && !$past(i_ext_master))
		else $error("bus taken mid core cycle");
	a_rw_apart: assert property (!(o_bus.rd && o_bus.wr))
		else $error("read and write together");
	// A slow slave must see one steady request until it answers
	a_req_held: assert property ((o_bus.rd || o_bus.wr) && !i_bus.ack && !i_bus.err |=> $stable(o_bus))
		else $error("request moved before answer");
	a_write_after_read: assert property ($rose(o_bus.wr) |-> $past(o_bus.rd))
		else $error("write without read");
endmodule : dma_channel_chk

bind dma_channel dma_channel_chk chk (.i_clk, .i_rst, .o_bus, .i_bus, .i_core_busy, .i_ext_master,
	.o_xfer_ack_n, .o_bus_grant_ack_n, .o_term_n, .o_term_oe, .o_int_level);

// ### verif/mem_model.sv
`timescale 1ns/1ns
module mem_model
	import dma_pkg::*;
(
	input wire logic i_clk,
	input wire sys_req_type i_req,
	input wire logic [1:0] i_fail,
	input wire logic i_slow,
	output sys_rsp_type o_rsp
);
	logic [15:0] mem_q [256];
	logic [1:0] wait_q = 2'h0;
	logic hit;
	logic bad;
	initial o_rsp = '0;
	// One answer per request, after one edge, or when slow four (three when it follows straight on an answer)
	assign hit = (i_req.rd || i_req.wr) && !o_rsp.ack && !o_rsp.err && (!i_slow || wait_q == 2'h3);
	assign bad = (i_fail[0] && i_req.rd) || (i_fail[1] && i_req.wr);
	always @(posedge i_clk) begin
		o_rsp.ack <= 1'b0;
		o_rsp.err <= 1'b0;
		// Idle data lines keep changing so stale data never passes
		o_rsp.rdata <= ~o_rsp.rdata;
		wait_q <= (i_req.rd || i_req.wr) ? wait_q + 2'h1 : 2'h0;
		if (hit) begin
			wait_q <= 2'h0;
			o_rsp.ack <= !bad;
			o_rsp.err <= bad;
			if (i_req.rd) o_rsp.rdata <= mem_q[i_req.addr[8:1]];
			if (i_req.wr && !i_req.byte_size) mem_q[i_req.addr[8:1]] <= i_req.wdata;
			if (i_req.wr && i_req.byte_size && !i_req.addr[0]) mem_q[i_req.addr[8:1]][15:8] <= i_req.wdata[15:8];
			if (i_req.wr && i_req.byte_size && i_req.addr[0]) mem_q[i_req.addr[8:1]][7:0] <= i_req.wdata[7:0];
		end
	end
endmodule : mem_model

// ### verif/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import dma_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic busy = 1'b0, ext = 1'b0, req_n = 1'b1, term_tb = 1'b1, term_en = 1'b0, steal = 1'b0;
	logic slow = 1'b0, saw_term = 1'b0, perr, xack_n, bga_n, term_n, term_oe, term_w;
	logic [1:0] fail = 2'h0;
	logic [2:0] lvl;
	logic [15:0] rnd = 16'h8b65;
	logic [31:0] rd;
	apb_req_type req = '0;
	apb_rsp_type rsp;
	sys_req_type bus;
	sys_rsp_type ans;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;

	dma_channel dut (.i_clk, .i_rst, .i_apb(req), .o_apb(rsp), .o_bus(bus), .i_bus(ans), .i_core_busy(busy),
		.i_ext_master(ext), .i_xfer_request_n(req_n), .o_xfer_ack_n(xack_n), .o_bus_grant_ack_n(bga_n),
		.i_term_n(term_w), .o_term_n(term_n), .o_term_oe(term_oe), .o_int_level(lvl));
	mem_model mem (.i_clk, .i_req(bus), .i_fail(fail), .i_slow(slow), .o_rsp(ans));

	always #5 i_clk = ~i_clk;
	// Terminate wire is pulled up; either party may pull it low
	assign term_w = term_tb & (term_oe ? term_n : 1'b1);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Packed word: even-lane bytes, first read lands high
	function automatic logic [15:0] pack(input logic [15:0] a, input logic [15:0] b);
		return {a[15:8], b[15:8]};
	endfunction : pack

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		req.penable <= 1'b1;
		// Hold the access until the slave answers
		do @(posedge i_clk); while (rsp.pready !== 1'b1 && ++n < 100);
		if (n >= 100) begin
			bad_count++;
			summarize();
		end
		rd = rsp.prdata;
		perr = rsp.pslverr;
		req <= '0;
	endtask : apb

	task automatic run(input logic [31:0] mode, input logic [15:0] cnt);
		int n;
		n = 0;
		for (int i = 0; i < 4; i++) mem.mem_q[128 + i] = 16'hdead;
		apb(1'b1, SRC_OFS, 32'h0);
		apb(1'b1, DST_OFS, 32'h100);
		apb(1'b1, COUNT_OFS, {16'h0, cnt});
		apb(1'b1, MODE_OFS, mode);
		// Poll until a completion, error or unsync flag shows
		do apb(1'b0, STATUS_OFS, 32'h0); while (rd[3:0] === 4'h0 && ++n < 300);
		if (n >= 300) begin
			bad_count++;
			summarize();
		end
	endtask : run

	// Random contention, steal pulses and peripheral terminate
	always @(posedge i_clk) begin
		rnd <= lfsr(rnd);
		busy <= rnd[0] & rnd[3];
		ext <= rnd[5] & rnd[9] & rnd[1];
		cyc <= cyc + 1;
		if (steal) req_n <= ~req_n;
		term_tb <= !(term_en && !xack_n);
		if (term_oe && !term_n) saw_term <= 1'b1;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		for (int i = 0; i < 128; i++) mem.mem_q[i] = lfsr(rnd ^ 16'(i * 7));
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(1'b0, MODE_OFS, 32'h0);
		chk("mode reset", {16'h0, MODE_RESET}, rd);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status reset", {24'h0, STATUS_RESET}, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, 32'(perr));
		$display("test reset done");
		// Every request mode, throttle only at its first bandwidth setting (mode 0), peripheral as destination
		for (int m = 0; m < 4; m++) begin
			steal <= 1'b0;
			@(posedge i_clk);
			steal <= (m == 3);
			req_n <= (m != 2);
			slow <= m[0];
			saw_term <= 1'b0;
			run(32'h43a1 | (m << 10) | (m << 2), 16'h4);
			chk("done", 32'h1, rd);
			chk("word0", {16'h0, mem.mem_q[0]}, {16'h0, mem.mem_q[128]});
			chk("word1", {16'h0, mem.mem_q[1]}, {16'h0, mem.mem_q[129]});
			chk("term out", 32'(m > 1), 32'(saw_term));
			apb(1'b1, STATUS_OFS, 32'h1);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk("w1c", 32'h0, rd);
			$display("test mode %0d done", m);
		end
		steal <= 1'b0;
		run(32'h4761, 16'h4);
		chk("pack0", {16'h0, pack(mem.mem_q[0], mem.mem_q[1])}, {16'h0, mem.mem_q[128]});
		chk("pack1", {16'h0, pack(mem.mem_q[2], mem.mem_q[3])}, {16'h0, mem.mem_q[129]});
		apb(1'b0, SRC_OFS, 32'h0);
		chk("src ptr", 32'h8, rd);
		apb(1'b1, STATUS_OFS, 32'h1);
		$display("test packing done");
		// Read then write error, interrupt masked then unmasked
		for (int k = 1; k < 3; k++) begin
			apb(1'b1, MASK_OFS, (k == 2) ? 32'h800 : 32'h0);
			fail <= k[1:0];
			run(32'h17a1, 16'h4);
			fail <= 2'h0;
			chk("err flags", (k == 1) ? 32'h4 : 32'h2, rd);
			repeat (2) @(posedge i_clk);
			chk("err irq", (k == 2) ? 32'h4 : 32'h0, {29'h0, lvl});
			apb(1'b1, MODE_OFS, 32'h2);
			apb(1'b1, MODE_OFS, 32'h0);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk("swrst clear", 32'h0, rd);
			$display("test error %0d done", k);
		end
		slow <= 1'b1;
		term_en <= 1'b1;
		req_n <= 1'b0;
		run(32'h6ba1, 16'h40);
		chk("term done", 32'h1, rd);
		repeat (2) @(posedge i_clk);
		chk("term irq", 32'h4, {29'h0, lvl});
		apb(1'b0, COUNT_OFS, 32'h0);
		chk("early stop", 32'h3e, rd);
		term_en <= 1'b0;
		apb(1'b1, STATUS_OFS, 32'hf);
		repeat (2) @(posedge i_clk);
		chk("irq cleared", 32'h0, {29'h0, lvl});
		$display("test terminate done");
		// Byte peripheral as source ends the block during its first byte
		term_en <= 1'b1;
		run(32'h0b61, 16'h4);
		repeat (20) @(posedge i_clk);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("unsync", 32'h9, rd);
		apb(1'b0, COUNT_OFS, 32'h0);
		chk("unsync count", 32'h2, rd);
		term_en <= 1'b0;
		$display("test unsync done");
		summarize();
	end
endmodule : tb_top
